// >>> mftc_asserts.sv
// checker: bus answer, blanking, row blank and frame latch properties
`timescale 1ns/10ps
module mftc_asserts (
   input wire logic        CLK_SYS,
   input wire logic        RSTN,
   input wire logic [5:0]  WB_ADR_I,
   input wire logic        WB_WE_I,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic        WB_ACK_O,
   input wire logic        WB_ERR_O,
   input wire logic        VSYNC,
   input wire logic [7:0]  PIX_OUT,
   input wire logic        ROW_PROG,
   input wire logic        ROW_BLANK_PULSE,
   input wire logic        ARRAY_BLACK,
   input wire logic        ODD_FIELD,
   input wire logic        STEREO_FRAME_SEQ,
   input wire logic        STEREO_FIELD_SEQ,
   input wire logic        MONO_TWO_CH
);
   logic       vs_q;
   logic [3:0] since_q;
   logic       rbc_nz_q;
   wire        req = WB_CYC_I && WB_STB_I;
   wire        map_w = WB_ADR_I[1:0] == 2'h0 && WB_ADR_I <= mftc_pkg::A_STAT;
   // cycles since frame sync fall, nonzero row blank count seen
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         vs_q     <= 1'b0;
         since_q  <= 4'hF;
         rbc_nz_q <= 1'b0;
      end else begin
         vs_q <= VSYNC;
         if (vs_q && !VSYNC) since_q <= 4'h0;
         else if (since_q != 4'hF) since_q <= since_q + 4'h1;
         if (WB_ACK_O && WB_WE_I && WB_ADR_I == mftc_pkg::A_RBC
             && WB_DAT_I[9:0] != 10'h000) rbc_nz_q <= 1'b1;
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   a_bus_answer: assert property (req && !WB_ACK_O && !WB_ERR_O
      |=> WB_ACK_O ^ WB_ERR_O) else $error("bus request not answered");
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   a_err_unmapped: assert property (WB_ERR_O |-> !$past(map_w))
      else $error("error on mapped address");
   a_ack_mapped: assert property (WB_ACK_O |-> $past(map_w))
      else $error("ack on unmapped address");
   a_black_until_write: assert property ($fell(ARRAY_BLACK) |->
      WB_ACK_O && WB_WE_I && WB_ADR_I == mftc_pkg::A_CTL)
      else $error("array shown without control write");
   a_black_pixels: assert property (ARRAY_BLACK[*3] |-> PIX_OUT == 8'h00)
      else $error("pixel not black while blanked");
   a_row_pulse: assert property (ROW_PROG |=> !ROW_PROG)
      else $error("row program pulse too long");
   a_no_blank_zero: assert property (ROW_BLANK_PULSE |-> rbc_nz_q)
      else $error("row blank pulse with zero count");
   a_stereo_excl: assert property (!(STEREO_FRAME_SEQ && STEREO_FIELD_SEQ))
      else $error("both stereo forms at once");
   a_frame_latch: assert property ($changed({ODD_FIELD, STEREO_FRAME_SEQ,
      STEREO_FIELD_SEQ, MONO_TWO_CH}) |-> since_q < 4'hF)
      else $error("mode outputs changed off frame boundary");
   cover property (ROW_BLANK_PULSE);
   cover property ($fell(ARRAY_BLACK));
   cover property (WB_ERR_O);
   cover property ($rose(STEREO_FIELD_SEQ));
endmodule // mftc_asserts

// >>> mftc_pkg.sv
// package: register map, field layouts and timing constants for format control
package mftc_pkg;
   localparam int ROW_W = 11;
   localparam int COL_W = 11;
   localparam logic [ROW_W-1:0] ARRAY_ROWS    = 11'h040C;
   localparam logic [COL_W-1:0] ARRAY_COLS    = 11'h050C;
   localparam logic [ROW_W-1:0] SHIFT_MAX     = 11'h000C;
   localparam logic [ROW_W-1:0] INIT_LINES    = 11'h0002;
   localparam logic [7:0]  TOP_RST   = 8'h06;
   localparam logic [7:0]  BOT_RST   = 8'h06;
   localparam logic [7:0]  LFT_RST   = 8'h06;
   localparam logic [7:0]  RGT_RST   = 8'h06;
   localparam logic [7:0]  VIN_RST   = 8'h00;
   localparam logic [7:0]  DISP_RST  = 8'h00;
   localparam logic [9:0]  RBC_RST   = 10'h000;
   localparam logic [7:0]  CTL_RST   = 8'h01;
   localparam logic [1:0]  SCAN_PROG = 2'h0;
   // register byte addresses
   localparam logic [5:0] A_VIN  = 6'h00;
   localparam logic [5:0] A_DISP = 6'h04;
   localparam logic [5:0] A_LFT  = 6'h08;
   localparam logic [5:0] A_RGT  = 6'h0C;
   localparam logic [5:0] A_TOP  = 6'h10;
   localparam logic [5:0] A_BOT  = 6'h14;
   localparam logic [5:0] A_CTL  = 6'h18;
   localparam logic [5:0] A_RBC  = 6'h1C;
   localparam logic [5:0] A_STAT = 6'h20;
   // field positions
   localparam int VIN_EN_POL  = 0;
   localparam int VIN_FLD_POL = 1;
   localparam int DM_VDIR     = 0;
   localparam int DM_HDIR     = 1;
   localparam int DM_SCAN_LO  = 2;
   localparam int DM_STEREO   = 4;
   localparam int DM_MONO     = 6;
   localparam int CTL_BLANK   = 0;

   typedef struct packed {
      logic [7:0] vin;
      logic [7:0] disp;
      logic [7:0] lft;
      logic [7:0] rgt;
      logic [7:0] top;
      logic [7:0] bot;
      logic [9:0] rbc;
   } mftc_cfg_s;

   typedef struct packed {
      logic        row_valid;
      logic [ROW_W-1:0] row;
      logic        odd_field;
      logic        stereo_frame;
      logic        stereo_field;
      logic        mono;
   } mftc_row_s;

   typedef enum logic [1:0] {ST_WAIT, ST_INIT, ST_ACTIVE} mftc_state_e;
endpackage

// >>> mftc_src_model.sv
// video source model: syncs, pixel clock, pixels and field select
`timescale 1ns/10ps
module mftc_src_model (
   output logic       PIX_CLK,
   output logic       HSYNC,
   output logic       VSYNC,
   output logic       SELECT_IN,
   output logic [7:0] PIX_IN
);
   initial begin
      PIX_CLK = 1'b0;
      HSYNC = 1'b0;
      VSYNC = 1'b0;
      SELECT_IN = 1'b0;
      PIX_IN = 8'h00;
   end
   // one line: sync pulse then four pixels, clock still after
   task automatic line_out(input logic [7:0] base);
      HSYNC = 1'b1;
      #160 HSYNC = 1'b0;
      #160;
      for (int p = 0; p < 4; p++) begin
         PIX_IN = base + 8'(p);
         #80 PIX_CLK = 1'b1;
         #80 PIX_CLK = 1'b0;
      end
      PIX_IN = ~PIX_IN;
      #160;
   endtask
   // select set once per frame from lvl and held for the whole frame
   task automatic frame(input int nl, input logic lvl);
      SELECT_IN = lvl;
      VSYNC = 1'b1;
      line_out(8'h00);
      line_out(8'h00);
      VSYNC = 1'b0;
      for (int l = 0; l < nl; l++) line_out(8'(l));
   endtask
endmodule // mftc_src_model

// >>> mftc_top.sv
// format and timing control: position, scan, field select, row blanking
`timescale 1ns/10ps
module mftc_top (
   input  wire logic                        CLK_SYS,
   input  wire logic                        RSTN,
   input  wire logic [5:0]                  WB_ADR_I,
   input  wire logic [31:0]                 WB_DAT_I,
   output logic      [31:0]                 WB_DAT_O,
   input  wire logic                        WB_WE_I,
   input  wire logic [3:0]                  WB_SEL_I,
   input  wire logic                        WB_CYC_I,
   input  wire logic                        WB_STB_I,
   output logic                             WB_ACK_O,
   output logic                             WB_ERR_O,
   input  wire logic                        PIX_CLK,
   input  wire logic                        HSYNC,
   input  wire logic                        VSYNC,
   input  wire logic                        SELECT_IN,
   input  wire logic [7:0]                  PIX_IN,
   output logic      [7:0]                  PIX_OUT,
   output logic      [mftc_pkg::COL_W-1:0]  COL_OUT,
   output logic                             PIX_VALID,
   output logic      [mftc_pkg::ROW_W-1:0]  ROW_OUT,
   output logic                             ROW_PROG,
   output logic      [mftc_pkg::ROW_W-1:0]  BLANK_ROW,
   output logic                             ROW_BLANK_PULSE,
   output logic                             ARRAY_BLACK,
   output logic                             ODD_FIELD,
   output logic                             STEREO_FRAME_SEQ,
   output logic                             STEREO_FIELD_SEQ,
   output logic                             MONO_TWO_CH
);
   // synchronisers
   logic [3:0] s1_q, s2_q, s3_q;
   logic [7:0] px1_q, px2_q;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         px1_q <= '0;
         px2_q <= '0;
      end else begin
         s1_q  <= {PIX_CLK, HSYNC, VSYNC, SELECT_IN};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         px1_q <= PIX_IN;
         px2_q <= px1_q;
      end
   end
   logic pclk_rise, hs_rise, vs_fall, sel_lvl;
   assign pclk_rise = s2_q[3] & ~s3_q[3];
   assign hs_rise   = s2_q[2] & ~s3_q[2];
   assign vs_fall   = ~s2_q[1] & s3_q[1];
   assign sel_lvl   = s2_q[0];

   // register file
   mftc_pkg::mftc_cfg_s cfg_q, cfg_d, act_q, act_d;
   logic [7:0]  ctl_q, ctl_d;
   logic        ack_q, ack_d, err_q, err_d;
   logic [31:0] rdat_q, rdat_d;
   logic        req, hit;
   assign req = WB_CYC_I & WB_STB_I & ~ack_q & ~err_q;

   // frame state
   mftc_pkg::mftc_state_e st_q, st_d;
   logic [mftc_pkg::ROW_W-1:0] line_q, line_d, row_q, row_d;
   logic [mftc_pkg::COL_W-1:0] col_q, col_d;
   logic [mftc_pkg::ROW_W:0] dly_wd, dly_rd;
   logic [mftc_pkg::ROW_W:0] dly_mem [1 << mftc_pkg::ROW_W];
   logic        sel_cap_q, sel_cap_d, prog_q, prog_d, pv_q, pv_d;
   logic        rbp_q, rbp_d, dly_we;
   logic [7:0]  pix_q, pix_d;
   logic [mftc_pkg::ROW_W-1:0] brow_q, brow_d;
   logic        sel_active, sel_live, fld_odd, interlaced;

   always_comb begin
      cfg_d  = cfg_q;
      ctl_d  = ctl_q;
      ack_d  = 1'b0;
      err_d  = 1'b0;
      rdat_d = rdat_q;
      hit    = 1'b1;
      case (WB_ADR_I)
         mftc_pkg::A_VIN:  rdat_d = {24'h00_0000, cfg_q.vin};
         mftc_pkg::A_DISP: rdat_d = {24'h00_0000, cfg_q.disp};
         mftc_pkg::A_LFT:  rdat_d = {24'h00_0000, cfg_q.lft};
         mftc_pkg::A_RGT:  rdat_d = {24'h00_0000, cfg_q.rgt};
         mftc_pkg::A_TOP:  rdat_d = {24'h00_0000, cfg_q.top};
         mftc_pkg::A_BOT:  rdat_d = {24'h00_0000, cfg_q.bot};
         mftc_pkg::A_CTL:  rdat_d = {24'h00_0000, ctl_q};
         mftc_pkg::A_RBC:  rdat_d = {22'h00_0000, cfg_q.rbc};
         mftc_pkg::A_STAT: rdat_d = {8'h00, 5'h00, row_q, 5'h00,
                                     sel_cap_q, (st_q == mftc_pkg::ST_ACTIVE),
                                     fld_odd};
         default: begin
            rdat_d = 32'h0000_0000;
            hit    = 1'b0;
         end
      endcase
      if (req) begin
         ack_d = hit;
         err_d = ~hit;
         if (WB_WE_I && hit && WB_SEL_I[0]) begin
            case (WB_ADR_I)
               mftc_pkg::A_VIN:  cfg_d.vin  = WB_DAT_I[7:0];
               mftc_pkg::A_DISP: cfg_d.disp = WB_DAT_I[7:0];
               mftc_pkg::A_LFT:  cfg_d.lft  = WB_DAT_I[7:0];
               mftc_pkg::A_RGT:  cfg_d.rgt  = WB_DAT_I[7:0];
               mftc_pkg::A_TOP:  cfg_d.top  = WB_DAT_I[7:0];
               mftc_pkg::A_BOT:  cfg_d.bot  = WB_DAT_I[7:0];
               mftc_pkg::A_CTL:  ctl_d      = WB_DAT_I[7:0];
               mftc_pkg::A_RBC:  cfg_d.rbc[7:0] = WB_DAT_I[7:0];
               default: ;
            endcase
         end
         if (WB_WE_I && hit && WB_SEL_I[1] && WB_ADR_I == mftc_pkg::A_RBC)
            cfg_d.rbc[9:8] = WB_DAT_I[9:8];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         cfg_q  <= '{mftc_pkg::VIN_RST, mftc_pkg::DISP_RST, mftc_pkg::LFT_RST,
                    mftc_pkg::RGT_RST, mftc_pkg::TOP_RST, mftc_pkg::BOT_RST,
                    mftc_pkg::RBC_RST};
         ctl_q  <= mftc_pkg::CTL_RST;
         ack_q  <= 1'b0;
         err_q  <= 1'b0;
         rdat_q <= '0;
      end else begin
         cfg_q  <= cfg_d;
         ctl_q  <= ctl_d;
         ack_q  <= ack_d;
         err_q  <= err_d;
         rdat_q <= rdat_d;
      end
   end
   assign WB_ACK_O = ack_q;
   assign WB_ERR_O = err_q;
   assign WB_DAT_O = rdat_q;

   // select decode from the frame-latched value
   assign sel_active = sel_cap_q ^ ~act_q.vin[mftc_pkg::VIN_EN_POL];
   // live select level masks both syncs in real time
   assign sel_live = sel_lvl ^ ~cfg_q.vin[mftc_pkg::VIN_EN_POL];
   assign interlaced = act_q.disp[mftc_pkg::DM_SCAN_LO+1 -: 2]
                       != mftc_pkg::SCAN_PROG;
   assign fld_odd = interlaced
                    & ~(sel_cap_q ^ act_q.vin[mftc_pkg::VIN_FLD_POL]);

   // frame, line and pixel sequencer
   logic [mftc_pkg::ROW_W-1:0] top_row, bot_row, prow, vis_line;
   logic [mftc_pkg::COL_W-1:0] lft_col, rgt_col, pcol;
   logic [11:0] rb_len;
   always_comb begin
      top_row  = {3'h0, act_q.top};
      bot_row  = mftc_pkg::ARRAY_ROWS - {3'h0, act_q.bot};
      lft_col  = {3'h0, act_q.lft};
      rgt_col  = mftc_pkg::ARRAY_COLS - {3'h0, act_q.rgt};
      vis_line = line_q - mftc_pkg::INIT_LINES;
      rb_len   = {1'b0, act_q.rbc, 1'b0};
      st_d      = st_q;
      act_d     = act_q;
      line_d    = line_q;
      row_d     = row_q;
      col_d     = col_q;
      sel_cap_d = sel_cap_q;
      prog_d    = 1'b0;
      pv_d      = 1'b0;
      pix_d     = pix_q;
      dly_we    = 1'b0;
      rbp_d     = 1'b0;
      dly_wd    = '0;
      dly_rd    = '0;
      brow_d    = brow_q;
      prow      = row_q;
      pcol      = col_q;
      if (!sel_live) begin
         st_d = mftc_pkg::ST_WAIT;
      end else if (vs_fall) begin
         sel_cap_d = sel_lvl;
         act_d     = cfg_q;
         line_d    = '0;
         col_d     = '0;
         st_d      = mftc_pkg::ST_INIT;
      end else if (!sel_active) begin
         st_d = mftc_pkg::ST_WAIT;
      end else if (hs_rise && st_q != mftc_pkg::ST_WAIT) begin
         line_d = line_q + 11'h001;
         col_d  = '0;
         if (line_q + 11'h001 >= mftc_pkg::INIT_LINES)
            st_d = mftc_pkg::ST_ACTIVE;
         if (st_q == mftc_pkg::ST_ACTIVE) begin
            // rows outside the window stay unprogrammed, i.e. blank margin
            if (interlaced)
               prow = {vis_line[mftc_pkg::ROW_W-2:0], ~fld_odd};
            else
               prow = vis_line;
            prow = prow + top_row;
            if (prow < bot_row && prow < mftc_pkg::ARRAY_ROWS) begin
               row_d  = act_q.disp[mftc_pkg::DM_VDIR]
                        ? mftc_pkg::ARRAY_ROWS - 11'h001 - prow
                        : prow;
               prog_d = 1'b1;
            end
         end
         // delay line: one entry per line, row and programmed flag
         dly_we = 1'b1;
         dly_wd = {prog_d, row_d};
         if (act_q.rbc != 10'h000 && {1'b0, line_q} >= rb_len) begin
            dly_rd = dly_mem[line_q - rb_len[mftc_pkg::ROW_W-1:0]];
            if (dly_rd[mftc_pkg::ROW_W]) begin
               rbp_d  = 1'b1;
               brow_d = dly_rd[mftc_pkg::ROW_W-1:0];
            end
         end
      end else if (pclk_rise && st_q == mftc_pkg::ST_ACTIVE) begin
         pcol  = col_q;
         col_d = col_q + 11'h001;
         pv_d  = col_q < mftc_pkg::ARRAY_COLS;
         // margin pixels go black as they enter the pixel register
         pix_d = (col_q < lft_col || col_q >= rgt_col) ? 8'h00 : px2_q;
         if (act_q.disp[mftc_pkg::DM_HDIR])
            pcol = mftc_pkg::ARRAY_COLS - 11'h001 - col_q;
      end
   end

   logic [mftc_pkg::COL_W-1:0] colo_q;
   always_ff @(posedge CLK_SYS) begin
      if (dly_we) dly_mem[line_q] <= dly_wd;
   end
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st_q      <= mftc_pkg::ST_WAIT;
         act_q     <= '{mftc_pkg::VIN_RST, mftc_pkg::DISP_RST,
                       mftc_pkg::LFT_RST, mftc_pkg::RGT_RST, mftc_pkg::TOP_RST,
                       mftc_pkg::BOT_RST, mftc_pkg::RBC_RST};
         line_q    <= '0;
         row_q     <= '0;
         col_q     <= '0;
         colo_q    <= '0;
         sel_cap_q <= 1'b0;
         prog_q    <= 1'b0;
         pv_q      <= 1'b0;
         pix_q     <= '0;
         rbp_q     <= 1'b0;
         brow_q    <= '0;
      end else begin
         st_q      <= st_d;
         act_q     <= act_d;
         line_q    <= line_d;
         row_q     <= row_d;
         col_q     <= col_d;
         colo_q    <= pcol;
         sel_cap_q <= sel_cap_d;
         prog_q    <= prog_d;
         pv_q      <= pv_d;
         pix_q     <= pix_d;
         rbp_q     <= rbp_d;
         brow_q    <= brow_d;
      end
   end

   assign PIX_OUT   = ctl_q[mftc_pkg::CTL_BLANK] ? 8'h00 : pix_q;
   assign COL_OUT   = colo_q;
   assign PIX_VALID = pv_q;
   assign ROW_OUT   = row_q;
   assign ROW_PROG  = prog_q;
   assign BLANK_ROW = brow_q;
   assign ROW_BLANK_PULSE = rbp_q;
   assign ARRAY_BLACK = ctl_q[mftc_pkg::CTL_BLANK];
   assign ODD_FIELD = fld_odd;
   assign STEREO_FRAME_SEQ = act_q.disp[mftc_pkg::DM_STEREO] & ~interlaced;
   assign STEREO_FIELD_SEQ = act_q.disp[mftc_pkg::DM_STEREO] & interlaced;
   assign MONO_TWO_CH = act_q.disp[mftc_pkg::DM_MONO];
endmodule // mftc_top

// >>> tb_top.sv
// testbench: registers, blanking, row blank timing, field and stereo
`timescale 1ns/10ps
module tb_top;
   logic        clk_sys, rstn, cyc, we, ack, err, got_err, hs_q;
   logic [5:0]  adr;
   logic [31:0] dat_w, dat_o, dat_r;
   logic        pclk, hs, vs, sel, prog, bpulse, black, odd;
   logic        sfrm, sfld, mono;
   logic [7:0]  pix, pix_o;
   logic        pv;
   logic [10:0] row_out, blank_row;
   int          failures = 0, cmp_count = 0, tmo = 0, hcnt = 0;
   int          nprog = 0, npulse = 0, prog_at [2048];
   bit          chk_rb = 0;
   mftc_top dut_u (
      .CLK_SYS(clk_sys), .RSTN(rstn), .WB_ADR_I(adr), .WB_DAT_I(dat_w),
      .WB_DAT_O(dat_o), .WB_WE_I(we), .WB_SEL_I(4'h3), .WB_CYC_I(cyc),
      .WB_STB_I(cyc), .WB_ACK_O(ack), .WB_ERR_O(err), .PIX_CLK(pclk),
      .HSYNC(hs), .VSYNC(vs), .SELECT_IN(sel), .PIX_IN(pix),
      .PIX_OUT(pix_o), .COL_OUT(), .PIX_VALID(pv), .ROW_OUT(row_out),
      .ROW_PROG(prog), .BLANK_ROW(blank_row), .ROW_BLANK_PULSE(bpulse),
      .ARRAY_BLACK(black), .ODD_FIELD(odd), .STEREO_FRAME_SEQ(sfrm),
      .STEREO_FIELD_SEQ(sfld), .MONO_TWO_CH(mono));
   mftc_src_model src_u (.PIX_CLK(pclk), .HSYNC(hs), .VSYNC(vs),
      .SELECT_IN(sel), .PIX_IN(pix));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      cyc <= 1'b1;
      adr <= a;
      we <= w;
      dat_w <= d;
      @(posedge clk_sys iff (ack === 1'b1 || err === 1'b1));
      dat_r = dat_o;
      got_err = err;
      cyc <= 1'b0;
   endtask
   // line count at each programmed row, blank pulse distance
   always @(posedge clk_sys) begin
      hs_q <= hs;
      if (hs && !hs_q) hcnt <= hcnt + 1;
      if (prog === 1'b1) prog_at[row_out] <= hcnt;
      if (prog === 1'b1) nprog <= nprog + 1;
      if (bpulse === 1'b1 && chk_rb) begin
         npulse <= npulse + 1;
         check(32'(hcnt - prog_at[blank_row]), 32'h0000_0004);
      end
      // source sends four pixels per line, all inside the left margin
      if (pv === 1'b1 && chk_rb) check(pix_o, 8'h00);
      tmo <= tmo + 1;
      if (tmo == 60000) begin
         failures++;
         summarize();
      end
   end
   task automatic t_reset();
      check(black, 1'b1);
      for (int i = 0; i < 4; i++) begin
         wb(mftc_pkg::A_LFT + 6'(4 * i), 1'b0, 32'h0000_0000);
         check(dat_r[7:0], 8'h06);
      end
      wb(mftc_pkg::A_CTL, 1'b0, 32'h0000_0000);
      check(dat_r[7:0], mftc_pkg::CTL_RST);
      wb(mftc_pkg::A_VIN, 1'b0, 32'h0000_0000);
      check(dat_r[7:0], 8'h00);
      wb(mftc_pkg::A_RBC, 1'b0, 32'h0000_0000);
      check(dat_r[9:0], 10'h000);
      wb(6'h3C, 1'b1, 32'h0000_0001);
      check(got_err, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_rowblank();
      wb(mftc_pkg::A_RBC, 1'b1, 32'h0000_0002);
      wb(mftc_pkg::A_CTL, 1'b1, 32'h0000_0000);
      @(negedge clk_sys);
      check(black, 1'b0);
      chk_rb = 1;
      src_u.frame(16, 1'b0);
      src_u.frame(4, 1'b0);
      check(32'(npulse > 0), 32'h0000_0001);
      $display("test row blank done");
   endtask
   task automatic t_field();
      logic [1:0] vin [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
      logic       lvl [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
      logic       exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      wb(mftc_pkg::A_DISP, 1'b1, 32'h0000_0004);
      for (int i = 0; i < 4; i++) begin
         wb(mftc_pkg::A_VIN, 1'b1, {30'h0000_0000, vin[i]});
         repeat (2) src_u.frame(3, lvl[i]);
         @(negedge clk_sys);
         check(odd, exp[i]);
      end
      $display("test field done");
   endtask
   task automatic t_stereo();
      logic [7:0] dm [4] = '{8'h10, 8'h14, 8'h40, 8'h00};
      logic [2:0] exp [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
      int         n0;
      for (int i = 0; i < 4; i++) begin
         wb(mftc_pkg::A_DISP, 1'b1, {24'h00_0000, dm[i]});
         src_u.frame(3, 1'b1);
         @(negedge clk_sys);
         check({sfrm, sfld, mono}, exp[i]);
      end
      n0 = nprog;
      wb(mftc_pkg::A_DISP, 1'b1, 32'h0000_0010);
      src_u.frame(3, 1'b0);
      @(negedge clk_sys);
      check(sfrm, 1'b0);
      check(32'(nprog - n0), 32'h0000_0000);
      check(black, 1'b0);
      $display("test stereo and mask done");
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      rstn = 1'b0;
      cyc = 1'b0;
      we = 1'b0;
      adr = 6'h00;
      dat_w = 32'h0000_0000;
      hs_q = 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_rowblank();
      t_field();
      t_stereo();
      summarize();
   end
endmodule // tb_top
bind mftc_top mftc_asserts chk_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
   .WB_ADR_I(WB_ADR_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
   .WB_ERR_O(WB_ERR_O), .VSYNC(VSYNC), .PIX_OUT(PIX_OUT),
   .ROW_PROG(ROW_PROG), .ROW_BLANK_PULSE(ROW_BLANK_PULSE),
   .ARRAY_BLACK(ARRAY_BLACK), .ODD_FIELD(ODD_FIELD),
   .STEREO_FRAME_SEQ(STEREO_FRAME_SEQ), .STEREO_FIELD_SEQ(STEREO_FIELD_SEQ),
   .MONO_TWO_CH(MONO_TWO_CH));
